// ===== logic/i2cmas_top.v
// Functional notes
// - In receive, after eighth falling SCL edge set event flag and buffer full.
// - After address byte, store slave acknowledge and set event after ninth clock.
// - Ack request pulls SCL low and drives the selected ack level.
// - Ack level is chosen before the acknowledge sequence starts.
// - Ack: SCL low one period, release, wait high, one period, pull low.
// - Ack end clears its request and goes idle; the rate counter keeps running.
// - Buffer write during ack or stop is dropped and sets write collision.
// - Stop: SDA low, count once, release SCL, one period later release SDA.
// - SDA high with SCL high sets halt flag; period later event, request clear.
// - Reset or disable aborts transfer and clears halt and begin flags.
// - A Stop seen on a busy bus while the master is idle sets the event flag.
// - Released SDA sampled low with SCL high sets bus collision, goes idle.
// - Collision in a byte halts shifting, clears buffer full, frees lines.
// - Collision in a condition aborts it and clears its request bits.
// - After collision a buffer write starts from the first bit.
// - Start with SDA or SCL already low aborts and flags collision.
// - Start: SDA high loads counter; SCL low while SDA high is collision.
// - SDA low during first start count restarts counter, drives SDA early.
// - Second start count ignores SCL low; at its end SCL is pulled low.
// - Arbitration is checked in address, data, start and acknowledge.
// - Rate counter reloads from rate reload value; two counts per clock.
//
// The APB interface to the registers and the address map were left to the implementer.
`include "i2cmas_defines.vh"

module i2cmas_top #(
    parameter RATE_RST = `I2CMAS_RATE_RST
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe
);

    localparam S_IDLE = 4'h0;
    localparam S_ST_A = 4'h1;
    localparam S_ST_B = 4'h2;
    localparam S_XLO = 4'h3;
    localparam S_XRISE = 4'h4;
    localparam S_XHI = 4'h5;
    localparam S_SP_A = 4'h6;
    localparam S_SP_B = 4'h7;
    localparam S_SP_C = 4'h8;
    localparam S_SP_D = 4'h9;
    localparam S_SP_E = 4'ha;
    localparam M_TX = 2'h0;
    localparam M_RX = 2'h1;
    localparam M_ACK = 2'h2;
    reg [3:0] state_q;
    reg [1:0] mode_q;
    reg [3:0] bit_q;
    reg [7:0] cnt_q;
    reg [7:0] rate_q;
    reg [7:0] buf_q;
    reg [7:0] shift_q;
    reg en_q;
    reg start_q;
    reg restart_q;
    reg stop_q;
    reg recv_q;
    reg acksend_q;
    reg acklvl_q;
    reg ack_received_status_q;
    reg event_q;
    reg rxfull_q;
    reg write_collision_flag_q;
    reg bcol_q;
    reg halt_q;
    reg begin_q;
    reg scl_m_q;
    reg scl_s_q;
    reg sda_m_q;
    reg sda_s_q;
    reg sda_p_q;
    wire [4:0] addr = paddr[4:0];
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire wr_ctrl = wr && addr == `I2CMAS_OFS_CTRL;
    wire wr_c2 = wr && addr == `I2CMAS_OFS_CTRL2;
    wire wr_stat = wr && addr == `I2CMAS_OFS_STAT;
    wire wr_buf = wr && addr == `I2CMAS_OFS_BUF;
    wire wr_rate = wr && addr == `I2CMAS_OFS_RATE;
    wire rd_buf = rd && addr == `I2CMAS_OFS_BUF;
    wire tick = cnt_q == 8'h00;
    wire out_bit = (mode_q == M_TX) ? shift_q[7] :
                   (mode_q == M_ACK) ? acklvl_q : 1'b1;
    wire last_bit = (mode_q == M_TX) ? (bit_q == 4'h8) :
                    (mode_q == M_RX) ? (bit_q == 4'h7) : 1'b1;
    wire bus_start = sda_p_q && !sda_s_q && scl_s_q;
    wire bus_stop = !sda_p_q && sda_s_q && scl_s_q;
    function mapped;
        input [4:0] a;
        begin
            mapped = a == `I2CMAS_OFS_CTRL || a == `I2CMAS_OFS_CTRL2 ||
                     a == `I2CMAS_OFS_STAT || a == `I2CMAS_OFS_BUF ||
                     a == `I2CMAS_OFS_RATE;
        end
    endfunction

    function w1c;
        input [4:0] a;
        input w;
        input [31:0] d;
        input integer b;
        begin
            w1c = w && a == `I2CMAS_OFS_STAT && d[b];
        end
    endfunction
    // Pins come from outside the clock domain, so two flops first.
    always @(posedge clk) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
        if (rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped(addr);
            prdata <= 32'h00000000;
            if (psel && penable && !pready && !pwrite) begin
                case (addr)
                    `I2CMAS_OFS_CTRL: prdata[`I2CMAS_CTRL_EN] <= en_q;
                    `I2CMAS_OFS_CTRL2: prdata[6:0] <= {ack_received_status_q,
                        acklvl_q, acksend_q, recv_q, stop_q, restart_q,
                        start_q};
                    `I2CMAS_OFS_STAT: prdata[5:0] <= {begin_q, halt_q,
                        bcol_q, write_collision_flag_q, rxfull_q, event_q};
                    `I2CMAS_OFS_BUF: prdata[7:0] <= buf_q;
                    `I2CMAS_OFS_RATE: prdata[7:0] <= rate_q;
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            mode_q <= M_TX;
            bit_q <= 4'h0;
            cnt_q <= 8'h00;
            rate_q <= RATE_RST[7:0];
            buf_q <= 8'h00;
            shift_q <= 8'h00;
            en_q <= 1'b0;
            start_q <= 1'b0;
            restart_q <= 1'b0;
            stop_q <= 1'b0;
            recv_q <= 1'b0;
            acksend_q <= 1'b0;
            acklvl_q <= 1'b0;
            ack_received_status_q <= 1'b0;
            event_q <= 1'b0;
            rxfull_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            bcol_q <= 1'b0;
            halt_q <= 1'b0;
            begin_q <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            // Sticky flags: a hardware set below overrides this clear.
            if (w1c(addr, wr, pwdata, `I2CMAS_ST_EVENT))
                event_q <= 1'b0;
            if (w1c(addr, wr, pwdata, `I2CMAS_ST_RXFULL))
                rxfull_q <= 1'b0;
            if (w1c(addr, wr, pwdata, `I2CMAS_ST_WRITE_COLLISION_FLAG))
                write_collision_flag_q <= 1'b0;
            if (w1c(addr, wr, pwdata, `I2CMAS_ST_BCOL))
                bcol_q <= 1'b0;
            if (rd_buf)
                rxfull_q <= 1'b0;
            if (wr_ctrl)
                en_q <= pwdata[`I2CMAS_CTRL_EN];
            if (wr_rate)
                rate_q <= pwdata[7:0];
            if (wr_c2) begin
                acklvl_q <= pwdata[`I2CMAS_C2_ACKLVL];
                if (state_q == S_IDLE) begin
                    start_q <= pwdata[`I2CMAS_C2_START];
                    restart_q <= pwdata[`I2CMAS_C2_RESTART];
                    stop_q <= pwdata[`I2CMAS_C2_STOP];
                    recv_q <= pwdata[`I2CMAS_C2_RECV];
                    acksend_q <= pwdata[`I2CMAS_C2_ACKSEND];
                end
            end
            if (bus_start) begin
                begin_q <= 1'b1;
                halt_q <= 1'b0;
            end
            if (bus_stop) begin
                halt_q <= 1'b1;
                begin_q <= 1'b0;
                if (state_q == S_IDLE && begin_q)
                    event_q <= 1'b1;
            end
            cnt_q <= tick ? rate_q : cnt_q - 8'h01;
            if (wr_buf) begin
                if (state_q != S_IDLE || !en_q) begin
                    write_collision_flag_q <= 1'b1;
                end else begin
                    buf_q <= pwdata[7:0];
                    shift_q <= pwdata[7:0];
                    rxfull_q <= 1'b1;
                    mode_q <= M_TX;
                    bit_q <= 4'h0;
                    cnt_q <= rate_q;
                    scl_oe <= 1'b1;
                    state_q <= S_XLO;
                end
            end
            case (state_q)
                S_IDLE: begin
                    if (!en_q || wr_buf) begin
                        state_q <= (wr_buf && en_q) ? S_XLO : S_IDLE;
                    end else if (start_q) begin
                        if (!sda_s_q || !scl_s_q) begin
                            bcol_q <= 1'b1;
                            start_q <= 1'b0;
                        end else begin
                            cnt_q <= rate_q;
                            state_q <= S_ST_A;
                        end
                    end else if (stop_q) begin
                        sda_oe <= 1'b1;
                        state_q <= S_SP_A;
                    end else if (acksend_q) begin
                        mode_q <= M_ACK;
                        bit_q <= 4'h0;
                        scl_oe <= 1'b1;
                        sda_oe <= !acklvl_q;
                        cnt_q <= rate_q;
                        state_q <= S_XLO;
                    end else if (recv_q) begin
                        mode_q <= M_RX;
                        bit_q <= 4'h0;
                        scl_oe <= 1'b1;
                        sda_oe <= 1'b0;
                        cnt_q <= rate_q;
                        state_q <= S_XLO;
                    end
                end
                S_ST_A: begin
                    if (!sda_s_q) begin
                        sda_oe <= 1'b1;
                        cnt_q <= rate_q;
                        state_q <= S_ST_B;
                    end else if (!scl_s_q) begin
                        bcol_q <= 1'b1;
                        start_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (tick) begin
                        sda_oe <= 1'b1;
                        state_q <= S_ST_B;
                    end
                end
                S_ST_B: begin
                    if (tick) begin
                        scl_oe <= 1'b1;
                        start_q <= 1'b0;
                        event_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_XLO: begin
                    sda_oe <= !out_bit;
                    if (tick) begin
                        scl_oe <= 1'b0;
                        state_q <= S_XRISE;
                    end
                end
                S_XRISE: begin
                    // Waiting here lets a slave stretch the clock.
                    if (scl_s_q) begin
                        cnt_q <= rate_q;
                        state_q <= S_XHI;
                    end
                end
                S_XHI: begin
                    if (!sda_oe && !sda_s_q && mode_q != M_RX &&
                        !(mode_q == M_TX && bit_q == 4'h8)) begin
                        bcol_q <= 1'b1;
                        if (mode_q == M_TX)
                            rxfull_q <= 1'b0;
                        acksend_q <= 1'b0;
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (tick) begin
                        scl_oe <= 1'b1;
                        cnt_q <= rate_q;
                        bit_q <= bit_q + 4'h1;
                        if (mode_q == M_TX)
                            shift_q <= {shift_q[6:0], 1'b1};
                        else
                            shift_q <= {shift_q[6:0], sda_s_q};
                        if (mode_q == M_TX && bit_q == 4'h7)
                            rxfull_q <= 1'b0;
                        if (last_bit) begin
                            state_q <= S_IDLE;
                            event_q <= 1'b1;
                            sda_oe <= 1'b0;
                            case (mode_q)
                                M_TX: ack_received_status_q <= sda_s_q;
                                M_RX: begin
                                    buf_q <= {shift_q[6:0], sda_s_q};
                                    rxfull_q <= 1'b1;
                                    recv_q <= 1'b0;
                                end
                                default: acksend_q <= 1'b0;
                            endcase
                        end else begin
                            state_q <= S_XLO;
                        end
                    end
                end
                S_SP_A: begin
                    if (!sda_s_q) begin
                        cnt_q <= rate_q;
                        state_q <= S_SP_B;
                    end
                end
                S_SP_B: begin
                    if (tick) begin
                        scl_oe <= 1'b0;
                        state_q <= S_SP_C;
                    end
                end
                S_SP_C: begin
                    if (tick) begin
                        sda_oe <= 1'b0;
                        state_q <= S_SP_D;
                    end
                end
                S_SP_D: begin
                    if (sda_s_q && scl_s_q) begin
                        cnt_q <= rate_q;
                        state_q <= S_SP_E;
                    end
                end
                S_SP_E: begin
                    if (tick) begin
                        stop_q <= 1'b0;
                        event_q <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase

            if (!en_q || (wr_ctrl && !pwdata[`I2CMAS_CTRL_EN])) begin
                state_q <= S_IDLE;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                halt_q <= 1'b0;
                begin_q <= 1'b0;
                start_q <= 1'b0;
                restart_q <= 1'b0;
                stop_q <= 1'b0;
                recv_q <= 1'b0;
                acksend_q <= 1'b0;
            end
        end
    end

endmodule

// ===== logic/i2cmas_defines.vh
`ifndef I2CMAS_DEFINES_VH
`define I2CMAS_DEFINES_VH

// Register byte offsets on the APB bus.
`define I2CMAS_OFS_CTRL 5'h00
`define I2CMAS_OFS_CTRL2 5'h04
`define I2CMAS_OFS_STAT 5'h08
`define I2CMAS_OFS_BUF 5'h0c
`define I2CMAS_OFS_RATE 5'h10

// Control register: module enable.
`define I2CMAS_CTRL_EN 0

// Control register two: requests and acknowledge bits.
`define I2CMAS_C2_START 0
`define I2CMAS_C2_RESTART 1
`define I2CMAS_C2_STOP 2
`define I2CMAS_C2_RECV 3
`define I2CMAS_C2_ACKSEND 4
`define I2CMAS_C2_ACKLVL 5
`define I2CMAS_C2_ACK_RECEIVED_STATUS 6

// Status register: flags, write one to clear bits 0 to 3; halt and begin are not cleared by a write.
`define I2CMAS_ST_EVENT 0
`define I2CMAS_ST_RXFULL 1
`define I2CMAS_ST_WRITE_COLLISION_FLAG 2
`define I2CMAS_ST_BCOL 3
`define I2CMAS_ST_HALT 4
`define I2CMAS_ST_BEGIN 5

// Reset value of the rate reload register.
`define I2CMAS_RATE_RST 8'h09

`endif

// ===== verif/i2cmas_chk.sv
module i2cmas_chk (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire scl_i,
    input wire scl_o,
    input wire scl_oe,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic ack_lvl_q = 1'b0;
    wire c2_wr = psel && penable && pready && pwrite && paddr[4:0] == 5'h04;
    wire ack_wr = c2_wr && pwdata[4] && pwdata[3:0] == 4'h0;
    wire stop_wr = c2_wr && pwdata[4:0] == 5'h04;
    always @(posedge clk) begin
        if (ack_wr) begin
            ack_lvl_q <= pwdata[5];
        end
    end
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    pready_access_a: assert property (pready |-> psel && penable
        && $past(psel && penable)) else $error("pready outside access");
    bad_addr_err_a: assert property (pready && paddr[4:0] > 5'h10
        |-> pslverr) else $error("unmapped access without error");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    open_drain_a: assert property (!scl_o && !sda_o)
        else $error("line output driven high");
    reset_free_a: assert property (
        disable iff (1'b0) rst |=> !scl_oe && !sda_oe && !pready)
        else $error("lines held through reset");
    ack_drive_a: assert property (
        ack_wr |-> ##[1:4] scl_oe && (sda_oe != ack_lvl_q))
        else $error("ack level not driven");
    stop_drive_a: assert property (
        stop_wr |-> ##[1:4] sda_oe && scl_oe)
        else $error("stop did not pull data low");
    low_hold_a: assert property ($rose(scl_oe) |-> scl_oe [*4])
        else $error("clock low shorter than a period");
    high_hold_a: assert property ($fell(scl_oe) |-> !scl_oe [*4])
        else $error("clock high shorter than a period");
    sda_order_a: assert property ($fell(sda_oe) |->
        $past(scl_oe) || !$past(scl_oe, 4))
        else $error("data released too soon after clock");
    cover property (ack_wr);
    cover property (stop_wr);
    cover property (pready && pslverr);
    cover property ($fell(sda_oe) && !scl_oe);
endmodule

bind i2cmas_top i2cmas_chk u_chk (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe));

// ===== verif/i2cmas_slave.sv
module i2cmas_slave (
    input wire logic scl,
    input wire logic sda,
    input wire logic grab,
    input wire logic stretch,
    input wire logic [7:0] tx_byte,
    output logic scl_oe,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    logic rd = 1'b0;
    logic drv = 1'b0;
    logic hold = 1'b0;
    // Grab models a rival master that keeps data low against us.
    assign sda_oe = grab || drv;
    assign scl_oe = hold;
    always @(negedge sda) begin
        if (scl) begin
            cnt = 0;
            rd = 1'b0;
            drv = 1'b0;
        end
    end
    always @(posedge scl) begin
        cnt = cnt + 1;
        if (cnt <= 8) begin
            sh = {sh[6:0], sda};
        end
    end
    always @(negedge scl) begin
        drv = 1'b0;
        if (cnt == 8 && sh[7:1] == 7'h50) begin
            drv = 1'b1;
            rd = sh[0];
        end
        if (rd && cnt >= 9 && cnt <= 16) begin
            drv = ~tx_byte[16 - cnt];
        end
        // Stretching makes the master wait on the line, not on its count.
        if (stretch) begin
            hold = 1'b1;
            #150 hold = 1'b0;
        end
    end
endmodule

// ===== verif/i2c_master_ack_stop_arbiter_tb.sv
module i2c_master_ack_stop_arbiter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RX = 32'h5c;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic grab = 1'b0;
    logic stretch = 1'b0;
    logic [31:0] r;
    logic e;
    wire [31:0] prdata;
    wire pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe;
    wire scl = !(scl_oe || s_scl_oe);
    wire sda = !(sda_oe || s_sda_oe);
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    i2cmas_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    i2cmas_slave slv (.scl(scl), .sda(sda), .grab(grab), .stretch(stretch),
        .tx_byte(RX[7:0]), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));
    task automatic summarize();
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {27'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] m,
        input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        cmp(r & m, x);
    endtask
    task automatic poll(input logic [4:0] a, input logic [31:0] m,
        input logic [31:0] x);
        do begin
            apb(1'b0, a, 32'h0);
        end while ((r & m) !== x);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic up();
        apb(1'b1, 5'h00, 32'h1);
        apb(1'b1, 5'h10, 32'h3);
    endtask
    initial begin
        do_reset();
        rchk(5'h04, 32'hffffffff, 32'h0);
        rchk(5'h08, 32'hffffffff, 32'h0);
        rchk(5'h10, 32'hffffffff, 32'h9);
        rchk(5'h14, 32'hffffffff, 32'h0);
        cmp({31'h0, e}, 32'h1);
        up();
        grab <= 1'b1;
        apb(1'b1, 5'h04, 32'h1);
        poll(5'h08, 32'h8, 32'h8);
        rchk(5'h04, 32'h1, 32'h0);
        cmp({30'h0, scl_oe, sda_oe}, 32'h0);
        grab <= 1'b0;
        poll(5'h08, 32'h11, 32'h11);
        apb(1'b1, 5'h08, 32'h3f);
        apb(1'b1, 5'h04, 32'h1);
        poll(5'h08, 32'h1, 32'h1);
        rchk(5'h04, 32'h1, 32'h0);
        apb(1'b1, 5'h08, 32'h3f);
        apb(1'b1, 5'h0c, 32'ha1);
        poll(5'h08, 32'h1, 32'h1);
        rchk(5'h04, 32'h40, 32'h0);
        apb(1'b1, 5'h08, 32'h3f);
        stretch <= 1'b1;
        apb(1'b1, 5'h04, 32'h8);
        poll(5'h08, 32'h1, 32'h1);
        rchk(5'h08, 32'h2, 32'h2);
        rchk(5'h0c, 32'hff, RX);
        rchk(5'h08, 32'h2, 32'h0);
        apb(1'b1, 5'h08, 32'h3f);
        apb(1'b1, 5'h04, 32'h30);
        apb(1'b1, 5'h0c, 32'h77);
        rchk(5'h08, 32'h4, 32'h4);
        poll(5'h04, 32'h10, 32'h0);
        rchk(5'h0c, 32'hff, RX);
        stretch <= 1'b0;
        apb(1'b1, 5'h08, 32'h3f);
        apb(1'b1, 5'h04, 32'h4);
        poll(5'h08, 32'h1, 32'h1);
        rchk(5'h08, 32'h10, 32'h10);
        rchk(5'h04, 32'h4, 32'h0);
        cmp({30'h0, scl_oe, sda_oe}, 32'h0);
        apb(1'b1, 5'h08, 32'h3f);
        apb(1'b1, 5'h04, 32'h1);
        poll(5'h08, 32'h1, 32'h1);
        apb(1'b1, 5'h08, 32'h3f);
        grab <= 1'b1;
        apb(1'b1, 5'h0c, 32'ha1);
        poll(5'h08, 32'h8, 32'h8);
        rchk(5'h08, 32'h2, 32'h0);
        cmp({30'h0, scl_oe, sda_oe}, 32'h0);
        grab <= 1'b0;
        poll(5'h08, 32'h10, 32'h10);
        apb(1'b1, 5'h08, 32'h3f);
        apb(1'b1, 5'h04, 32'h1);
        poll(5'h08, 32'h1, 32'h1);
        apb(1'b1, 5'h08, 32'h3f);
        apb(1'b1, 5'h0c, 32'ha0);
        poll(5'h08, 32'h1, 32'h1);
        rchk(5'h04, 32'h40, 32'h0);
        do_reset();
        cmp({30'h0, scl_oe, sda_oe}, 32'h0);
        cmp({30'h0, scl_o, sda_o}, 32'h0);
        rchk(5'h08, 32'h3f, 32'h0);
        rchk(5'h00, 32'h1, 32'h0);
        summarize();
    end
endmodule
